// >>> rtl/tecu_pkg.sv
// Package of the timer/event counter unit: register map, fields, resets.
// Assumes a 32-bit APB slave with byte addresses, one word per register.
package tecu_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CTL0 = 8'h00;
    localparam logic [7:0] OFS_CTL1 = 8'h04;
    localparam logic [7:0] OFS_IOC0 = 8'h08;
    localparam logic [7:0] OFS_IOC1 = 8'h0C;
    localparam logic [7:0] OFS_NFC  = 8'h10;
    localparam logic [7:0] OFS_CCR0 = 8'h14;
    localparam logic [7:0] OFS_CNT  = 8'h24;
    localparam logic [7:0] OFS_STAT = 8'h28;
    localparam logic [7:0] OFS_MASK = 8'h2C;

    // ==========================================================
    // Field positions
    localparam int CTL0_RUN     = 0;
    localparam int CTL1_MD_LSB  = 0;
    localparam int CTL1_EEE     = 5;
    localparam int CTL1_PRS_LSB = 8;
    localparam int IOC1_IS_LSB  = 0;
    localparam int IOC1_ES_LSB  = 2;
    localparam int NFC_CLK_LSB  = 0;
    localparam int NFC_CNT_BIT  = 6;
    localparam logic [7:0] NFC_USED = 8'h47;

    // Status and mask layout
    localparam int ST_CC0 = 0;
    localparam int ST_OVF = 4;
    localparam int ST_CAP = 5;
    localparam int ST_W   = 6;

    // ==========================================================
    // Values after reset
    localparam logic [ST_W-1:0] RST_MASK = 6'h3F;
    localparam logic [15:0]     RST_CCR  = 16'hFFFF;
    localparam logic [7:0]      RST_NFC  = 8'h00;

    typedef enum logic [2:0] {
        MODE_INTERVAL = 3'b000,
        MODE_EVENT    = 3'b001,
        MODE_EXT_TRIG = 3'b010,
        MODE_ONE_SHOT = 3'b011,
        MODE_PWM      = 3'b100,
        MODE_FREE     = 3'b101,
        MODE_PULSE    = 3'b110,
        MODE_TRI_PWM  = 3'b111
    } tecu_mode_e;

    typedef struct packed {
        logic       run;
        tecu_mode_e mode;
        logic       eee;
        logic [2:0] prs;
    } tecu_ctl_s;

    typedef struct packed {
        logic [1:0] cnt_edge;
        logic [1:0] cap_edge;
    } tecu_edge_s;

endpackage : tecu_pkg

// >>> rtl/tecu_prescaler.sv
// Free-running divider giving one-cycle enables at pclk / 2**n.
// Assumes a single clock domain; tick[0] is high every cycle.
`timescale 1ns/1ps
module tecu_prescaler
    import tecu_pkg::*;
#(
    parameter int NDIV = 8
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    output logic      [NDIV-1:0] tick
);

    logic [NDIV-1:0] div_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end

    // ==========================================================
    // Tick n fires when the low n bits are all ones
    genvar n;
    generate
        for (n = 0; n < NDIV; n++) begin : g_tick
            if (n == 0) begin : g_first
                assign tick[n] = 1'b1;
            end else begin : g_rest
                assign tick[n] = &div_ff[n-1:0];
            end
        end
    endgenerate

endmodule : tecu_prescaler

// >>> rtl/tecu_noise_filter.sv
// Digital noise filter for one timer input pin.
// Assumes an asynchronous pin; it is synchronised here before use.
`timescale 1ns/1ps
module tecu_noise_filter
    import tecu_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    input  wire logic smp_tick,
    input  wire logic three_smp,
    output logic      flt
);

    logic       sync1_ff;
    logic       sync2_ff;
    logic [2:0] hist_ff;
    logic       flt_ff;
    logic       agree;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end else begin
            sync1_ff <= pin;
            sync2_ff <= sync1_ff;
        end
    end

    // Filtering runs from reset, before any configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_ff <= 3'h0;
        end else if (smp_tick) begin
            hist_ff <= {hist_ff[1:0], sync2_ff};
        end
    end

    assign agree = three_smp ? (&hist_ff | ~|hist_ff)
                             : (&hist_ff[1:0] | ~|hist_ff[1:0]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flt_ff <= 1'b0;
        end else if (agree) begin
            flt_ff <= hist_ff[0];
        end
    end

    assign flt = flt_ff;

    property p_flt_stable;
        @(posedge pclk) disable iff (!presetn)
        (flt_ff != $past(flt_ff)) |-> ($past(hist_ff[1]) == flt_ff);
    endproperty
    a_flt_stable: assert property (p_flt_stable)
        else $error("filter output changed without agreeing samples");

endmodule : tecu_noise_filter

// >>> rtl/tecu_top.sv
// Timer/event counter unit: APB registers, filters, 16-bit counter.
// Assumes a single 100 MHz pclk and asynchronous input pins.
//
// Summary of operation
// - Input pins are noise filtered from reset, before configuration.
// - Counter above a lowered compare 0 counts on and wraps 16 bits.
// - External count clock only from pin 0; its capture edge disabled.
// - No timer output in event count mode.
`timescale 1ns/1ps
module tecu_top
    import tecu_pkg::*;
#(
    parameter int NPIN = 4,
    parameter int NDIV = 8
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic [NPIN-1:0] timer_input_pin_m,
    output logic      [3:1]      timer_output_k,
    output logic                 irq
);

    // ==========================================================
    // Register state
    tecu_ctl_s         ctl_ff;
    tecu_edge_s        edge_ff;
    logic [3:1]        oe_ff;
    logic [7:0]        nfc_ff;
    logic [15:0]       ccr_ff [0:3];
    logic [15:0]       cnt_ff;
    logic [ST_W-1:0]   stat_ff;
    logic [ST_W-1:0]   mask_ff;
    logic [3:1]        to_ff;
    logic              irq_ff;
    logic [31:0]       prdata_ff;
    logic              pready_ff;
    logic              pslverr_ff;
    logic              ev_prev_ff;

    logic              setup;
    logic              wr_acc;
    logic              rd_stat;
    logic [31:0]       rdata;
    logic              hit;
    logic [NDIV-1:0]   tick;
    logic [NPIN-1:0]   flt;
    logic              ext_sel;
    logic              ev_edge;
    logic              cap_det;
    logic              cnt_tick;
    logic              cc0_hit;
    logic              clr_on_cc0;
    logic [ST_W-1:0]   set_bits;
    logic [3:1]        cck_hit;

    // ==========================================================
    // APB slave: no wait states, read data captured in setup
    assign setup   = psel & ~penable;
    assign wr_acc  = psel & penable & pready_ff & pwrite;
    assign rd_stat = psel & penable & pready_ff & ~pwrite
                     & (paddr == OFS_STAT);

    always_comb begin
        rdata = 32'h0000_0000;
        hit   = 1'b1;
        unique case (paddr)
            OFS_CTL0: rdata[CTL0_RUN] = ctl_ff.run;
            OFS_CTL1: begin
                rdata[CTL1_MD_LSB +: 3]  = ctl_ff.mode;
                rdata[CTL1_EEE]          = ctl_ff.eee;
                rdata[CTL1_PRS_LSB +: 3] = ctl_ff.prs;
            end
            OFS_IOC0: rdata[3:1] = oe_ff;
            OFS_IOC1: begin
                rdata[IOC1_IS_LSB +: 2] = edge_ff.cap_edge;
                rdata[IOC1_ES_LSB +: 2] = edge_ff.cnt_edge;
            end
            OFS_NFC:  rdata[7:0] = nfc_ff & NFC_USED;
            OFS_CNT:  rdata[15:0] = cnt_ff;
            OFS_STAT: rdata[ST_W-1:0] = stat_ff;
            OFS_MASK: rdata[ST_W-1:0] = mask_ff;
            default: begin
                if (paddr >= OFS_CCR0 && paddr < OFS_CNT
                    && paddr[1:0] == 2'b00) begin
                    rdata[15:0] = ccr_ff[paddr[3:2] - 2'd1];
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~hit;
            if (setup && !pwrite) begin
                prdata_ff <= rdata;
            end
        end
    end

    // ==========================================================
    // Control and configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_ff  <= '{run: 1'b0, mode: MODE_INTERVAL, eee: 1'b0,
                         prs: 3'h0};
            edge_ff <= '0;
            oe_ff   <= 3'h0;
            nfc_ff  <= RST_NFC;
            mask_ff <= RST_MASK;
        end else if (wr_acc) begin
            unique case (paddr)
                OFS_CTL0: ctl_ff.run <= pwdata[CTL0_RUN];
                OFS_CTL1: begin
                    ctl_ff.mode <= tecu_mode_e'(pwdata[CTL1_MD_LSB +: 3]);
                    ctl_ff.eee  <= pwdata[CTL1_EEE];
                    ctl_ff.prs  <= pwdata[CTL1_PRS_LSB +: 3];
                end
                OFS_IOC0: oe_ff <= pwdata[3:1];
                OFS_IOC1: begin
                    edge_ff.cap_edge <= pwdata[IOC1_IS_LSB +: 2];
                    edge_ff.cnt_edge <= pwdata[IOC1_ES_LSB +: 2];
                end
                // Reserved filter bits are dropped on write
                OFS_NFC:  nfc_ff <= pwdata[7:0] & NFC_USED;
                OFS_MASK: mask_ff <= pwdata[ST_W-1:0];
                default: ;
            endcase
        end
    end

    // Compare registers take effect at once, even while counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                ccr_ff[i] <= RST_CCR;
            end
        end else if (wr_acc && paddr >= OFS_CCR0 && paddr < OFS_CNT
                     && paddr[1:0] == 2'b00) begin
            ccr_ff[paddr[3:2] - 2'd1] <= pwdata[15:0];
        end
    end

    // ==========================================================
    // Dividers and input filters
    tecu_prescaler #(
        .NDIV (NDIV)
    ) u_prescaler (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    genvar p;
    generate
        for (p = 0; p < NPIN; p++) begin : g_filter
            tecu_noise_filter u_filter (
                .pclk      (pclk),
                .presetn   (presetn),
                .pin       (timer_input_pin_m[p]),
                .smp_tick  (tick[nfc_ff[NFC_CLK_LSB +: 3]]),
                .three_smp (nfc_ff[NFC_CNT_BIT]),
                .flt       (flt[p])
            );
        end
    endgenerate

    // ==========================================================
    // Edge detection on the filtered channel 0 input
    function automatic logic edge_of(input logic [1:0] sel,
                                     input logic       prev,
                                     input logic       cur);
        unique case (sel)
            2'b00: edge_of = 1'b0;
            2'b01: edge_of = ~prev & cur;
            2'b10: edge_of = prev & ~cur;
            2'b11: edge_of = prev ^ cur;
        endcase
    endfunction : edge_of

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_prev_ff <= 1'b0;
        end else begin
            ev_prev_ff <= flt[0];
        end
    end

    // External clock comes only from pin 0, which then loses capture
    assign ext_sel = (ctl_ff.mode == MODE_EVENT) | ctl_ff.eee;
    assign ev_edge = edge_of(edge_ff.cnt_edge, ev_prev_ff, flt[0]);
    assign cap_det = ~ext_sel
                     & edge_of(edge_ff.cap_edge, ev_prev_ff, flt[0]);
    assign cnt_tick = ctl_ff.run
                      & (ext_sel ? ev_edge : tick[ctl_ff.prs]);

    // ==========================================================
    // 16-bit counter
    assign cc0_hit    = (cnt_ff == ccr_ff[0]);
    assign clr_on_cc0 = (ctl_ff.mode != MODE_FREE)
                        & (ctl_ff.mode != MODE_PULSE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 16'h0000;
        end else if (!ctl_ff.run) begin
            cnt_ff <= 16'h0000;
        end else if (cnt_tick) begin
            if (clr_on_cc0 && cc0_hit) begin
                cnt_ff <= 16'h0000;
            end else begin
                cnt_ff <= cnt_ff + 16'h0001;
            end
        end
    end

    // ==========================================================
    // Compare k events and timer outputs
    genvar k;
    generate
        for (k = 1; k <= 3; k++) begin : g_cmp
            assign cck_hit[k] = cnt_tick & (cnt_ff == ccr_ff[k]);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    to_ff[k] <= 1'b0;
                end else if (ctl_ff.mode == MODE_EVENT || !oe_ff[k]
                             || !ctl_ff.run) begin
                    to_ff[k] <= 1'b0;
                end else if (cck_hit[k]) begin
                    to_ff[k] <= ~to_ff[k];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Sticky status, cleared by read; a new event wins over the clear
    always_comb begin
        set_bits          = '0;
        set_bits[ST_CC0]  = cnt_tick & cc0_hit;
        set_bits[3:1]     = cck_hit;
        set_bits[ST_OVF]  = cnt_tick & (cnt_ff == 16'hFFFF)
                            & ~(clr_on_cc0 & cc0_hit);
        set_bits[ST_CAP]  = cap_det;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_ff <= '0;
        end else begin
            stat_ff <= (stat_ff & ~(rd_stat ? prdata_ff[ST_W-1:0] : '0))
                       | set_bits;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(stat_ff & ~mask_ff);
        end
    end

    assign prdata         = prdata_ff;
    assign pready         = pready_ff;
    assign pslverr        = pslverr_ff;
    assign timer_output_k = to_ff;
    assign irq            = irq_ff;

    // ==========================================================
    // Checks
    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        (cnt_tick && cnt_ff == 16'hFFFF && !(clr_on_cc0 && cc0_hit))
        |=> (cnt_ff == 16'h0000) && stat_ff[ST_OVF];
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter did not wrap through zero");
    property p_past_cc0;
        @(posedge pclk) disable iff (!presetn)
        (cnt_tick && cnt_ff > ccr_ff[0] && cnt_ff != 16'hFFFF)
        |=> (cnt_ff == $past(cnt_ff) + 16'h0001);
    endproperty
    a_past_cc0: assert property (p_past_cc0)
        else $error("counter above compare 0 did not count on");
    property p_no_out;
        @(posedge pclk) disable iff (!presetn)
        (ctl_ff.mode == MODE_EVENT) [*2] |-> (timer_output_k == 3'h0);
    endproperty
    a_no_out: assert property (p_no_out)
        else $error("timer output active in event count mode");
    property p_no_cap;
        @(posedge pclk) disable iff (!presetn)
        ext_sel && !stat_ff[ST_CAP] |=> !stat_ff[ST_CAP];
    endproperty
    a_no_cap: assert property (p_no_cap)
        else $error("capture edge seen with external clock selected");
    property p_ev_count;
        @(posedge pclk) disable iff (!presetn)
        (ctl_ff.run && ctl_ff.mode == MODE_EVENT && ev_edge && !cc0_hit)
        |=> (cnt_ff == $past(cnt_ff) + 16'h0001);
    endproperty
    a_ev_count: assert property (p_ev_count)
        else $error("event edge did not advance the counter");
    property p_ev_match;
        @(posedge pclk) disable iff (!presetn)
        (ctl_ff.run && ctl_ff.mode == MODE_EVENT && ev_edge && cc0_hit)
        |=> (cnt_ff == 16'h0000) && stat_ff[ST_CC0]
            ##1 (irq_ff || mask_ff[ST_CC0]);
    endproperty
    a_ev_match: assert property (p_ev_match)
        else $error("compare 0 match did not clear and interrupt");
endmodule : tecu_top

// >>> sim/tb.sv
// Self-checking bench of the timer/event counter unit, driven over APB.
// Assumes tecu_pkg and tecu_top compiled first; one 100 MHz clock.
`timescale 1ns/1ps
module tb;
    import tecu_pkg::*;

    // ==========================================================
    // Signals
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  pins;
    logic [3:1]  tout;
    logic        irq;
    int          err_total;
    int          n_compared;
    int          cyc;

    tecu_top #(.NPIN(4), .NDIV(8)) u_dut (
        .pclk              (pclk),
        .presetn           (presetn),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .timer_input_pin_m (pins),
        .timer_output_k    (tout),
        .irq               (irq)
    );

    // ==========================================================
    // Clock, reset and hang guard
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            err_total++;
            $display("unexpected at %0t: run too long", $time);
            finish_test();
        end
    end

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    // ==========================================================
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            $display("unexpected at %0t: no pready", $time);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, 32'h0, "write error flag");
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, d, e);
        chk({31'h0, e}, 32'h0, "read error flag");
    endtask : rd

    task automatic pulse(input int ch, input int hi);
        @(posedge pclk);
        pins[ch] <= 1'b1;
        repeat (hi) @(posedge pclk);
        pins[ch] <= 1'b0;
        repeat (12) @(posedge pclk);
    endtask : pulse

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        logic [31:0] d;
        logic        e;
        rd(OFS_CTL1, d); chk(d, 32'h0, "ctl1 reset");
        rd(OFS_NFC, d);  chk(d, {24'h0, RST_NFC}, "nfc reset");
        rd(OFS_CCR0, d); chk(d, {16'h0, RST_CCR}, "ccr0 reset");
        rd(OFS_MASK, d); chk(d, {26'h0, RST_MASK}, "mask reset");
        rd(OFS_STAT, d); chk(d, 32'h0, "stat reset");
        wr(OFS_NFC, 32'hFF);
        rd(OFS_NFC, d);  chk(d, {24'h0, NFC_USED}, "nfc loose bits");
        wr(OFS_NFC, 32'h0);
        apb(1'b1, 8'h30, 32'h1234, d, e);
        chk({31'h0, e}, 32'h1, "unmapped write err");
        apb(1'b0, 8'h30, 32'h0, d, e);
        chk(d, 32'h0, "unmapped read data");
        chk({31'h0, e}, 32'h1, "unmapped read err");
        $display("test regs done");
    endtask : t_regs

    task automatic t_event();
        logic [31:0] d;
        wr(OFS_CTL1, 32'h1);
        wr(OFS_IOC1, 32'h4);   // Count rise, capture off
        wr(OFS_CCR0, 32'h3);
        wr(OFS_IOC0, 32'hE);
        wr(OFS_MASK, 32'h0);
        wr(OFS_NFC, 32'h0);
        repeat (2) @(posedge pclk);
        wr(OFS_CTL0, 32'h1);
        pulse(0, 1);
        rd(OFS_CNT, d); chk(d, 32'h0, "glitch not counted");
        pulse(1, 12);
        rd(OFS_CNT, d); chk(d, 32'h0, "other pin no count");
        pulse(0, 12);
        pulse(0, 12);
        rd(OFS_CNT, d); chk(d, 32'h2, "two edges");
        chk({29'h0, tout}, 32'h0, "no output in event mode");
        pulse(0, 12);
        rd(OFS_CNT, d);
        chk(d, 32'h3, "three edges");
        chk({31'h0, irq}, 32'h0, "irq before match");
        pulse(0, 12);
        chk({31'h0, irq}, 32'h1, "irq at match");
        rd(OFS_CNT, d);
        chk(d, 32'h0, "cleared by match");
        pulse(0, 12);
        rd(OFS_CNT, d);
        chk(d, 32'h1, "counts on after match");
        wr(OFS_MASK, 32'h3F);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(OFS_MASK, 32'h0);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h1, "irq unmasked");
        rd(OFS_STAT, d); chk(d, 32'h1, "cc0 only, no capture");
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0, "irq cleared by read");
        chk({29'h0, tout}, 32'h0, "still no output");
        wr(OFS_CTL0, 32'h0);
        $display("test event done");
    endtask : t_event

    task automatic t_lower();
        logic [31:0] d;
        logic        ovf;
        int          n;
        wr(OFS_MASK, 32'h3F);
        wr(OFS_IOC1, 32'h0);
        wr(OFS_CTL1, 32'h0);
        wr(OFS_CCR0, 32'h100);
        rd(OFS_STAT, d);
        wr(OFS_CTL0, 32'h1);
        repeat (40) @(posedge pclk);
        rd(OFS_CNT, d);
        chk({31'h0, d > 32'h10 && d < 32'hF0}, 32'h1, "cnt mid run");
        wr(OFS_CCR0, 32'h10);
        ovf = 1'b0;
        n = 0;
        while (!ovf && n < 25000) begin
            rd(OFS_STAT, d);
            ovf = d[ST_OVF];
            if (!ovf && d[ST_CC0]) begin
                chk(d, 32'h0, "match before wrap");
            end
            n++;
        end
        chk({31'h0, ovf}, 32'h1, "wrap overflow seen");
        repeat (30) @(posedge pclk);
        rd(OFS_CNT, d);
        chk({31'h0, d <= 32'h10}, 32'h1, "new period after wrap");
        wr(OFS_CTL0, 32'h0);
        wr(OFS_CCR0, 32'h8);
        wr(OFS_CTL0, 32'h1);
        repeat (30) @(posedge pclk);
        rd(OFS_CNT, d);
        chk({31'h0, d <= 32'h8}, 32'h1, "lowered while stopped");
        wr(OFS_CTL0, 32'h0);
        $display("test lower done");
    endtask : t_lower

    task automatic t_free();
        logic [31:0] d;
        wr(OFS_MASK, 32'h3F);
        wr(OFS_CCR0, 32'h10);
        for (int m = 5; m <= 6; m++) begin
            wr(OFS_CTL1, 32'(m));
            wr(OFS_CTL0, 32'h1);
            repeat (40) @(posedge pclk);
            rd(OFS_CNT, d);
            chk({31'h0, d > 32'h10}, 32'h1, "no clear on compare 0");
            wr(OFS_CTL0, 32'h0);
        end
        $display("test free done");
    endtask : t_free

    task automatic t_ext();
        logic [31:0] d;
        wr(OFS_MASK, 32'h3F);
        wr(OFS_IOC0, 32'hE);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CCR0 + 8'(4 * i), 32'h1);
        end
        wr(OFS_IOC1, 32'h5);   // Count rise, capture rise asked
        wr(OFS_CTL1, 32'h20);
        rd(OFS_STAT, d);
        wr(OFS_CTL0, 32'h1);
        pulse(0, 12);
        pulse(0, 12);
        chk({29'h0, tout}, 32'h7, "outputs toggle on ext clock");
        rd(OFS_STAT, d);
        chk(d, 32'hF, "compares, no capture");
        chk({31'h0, irq}, 32'h0, "compare irqs masked");
        wr(OFS_CTL0, 32'h0);
        $display("test ext done");
    endtask : t_ext

    // ==========================================================
    // Main sequence
    initial begin
        err_total  = 0;
        n_compared = 0;
        cyc        = 0;
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        pins       = 4'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_event();
        t_lower();
        t_free();
        t_ext();
        finish_test();
    end

endmodule : tb
